// [pkg/rh_map.svh]
// register offsets, field positions, reset values and timing counts
// assumes byte offsets within the host controller register window
`ifndef RH_MAP_SVH
`define RH_MAP_SVH

`define RH_OFS_LS_THRESHOLD    8'h44
`define RH_OFS_DESCRIPTOR_A    8'h48
`define RH_OFS_DESCRIPTOR_B    8'h4C
`define RH_OFS_HUB_STATUS      8'h50

`define RH_LST_RESET           12'h628
`define RH_PGW_RESET           8'hFF
`define RH_NO_OVERCURRENT_PROTECT_RESET          1'b0
`define RH_NPS_RESET           1'b0
`define RH_PSM_RESET           1'b1
`define RH_FI_NOMINAL          14'h2EDF

`define RH_A_PGW_HI            31
`define RH_A_PGW_LO            24
`define RH_A_NO_OVERCURRENT_PROTECT              12
`define RH_A_OVERCURRENT_REPORT_MODE              11
`define RH_A_COMPOUND          10
`define RH_A_NPS               9
`define RH_A_PSM               8
`define RH_B_PER_PORT_POWER_MASK_LO           16

`define RH_S_CLR_WAKE          31
`define RH_S_OC_CHANGE         17
`define RH_S_GLOBAL_ON         16
`define RH_S_WAKE_EN           15
`define RH_S_GLOBAL_OC         1
`define RH_S_GLOBAL_OFF        0

`define RH_CLK_NS              10
`define RH_BIT_TIME_NS         83
`define RH_BIT_CYCLES          ((`RH_BIT_TIME_NS) / (`RH_CLK_NS))
`define RH_PGW_UNIT_MS         2

`endif

// [pkg/rh_pkg.sv]
// types shared by the root hub register logic
// assumes nothing beyond the map header
package rh_pkg;
  typedef enum logic [1:0] {
    RH_OPERATIONAL = 2'b00,
    RH_SUSPEND     = 2'b01,
    RH_RESUME      = 2'b11
  } rh_state_type;
endpackage

// [hdl/rh_frame_timer.sv]
// frame bit-time down counter with its own bit-time divider
// assumes frame_interval is stable or changes only between frames
`timescale 1ns/10ps
`include "rh_map.svh"
module rh_frame_timer #(
  parameter int BIT_CYCLES = `RH_BIT_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [13:0] frame_interval,
  output logic      [13:0] bit_time_left
);
  import rh_pkg::*;

  initial begin
    if (BIT_CYCLES < 1 || BIT_CYCLES > 255) $error("bit time divider out of range");
  end

  logic [7:0] div_reg;
  logic       bit_tick;

  ////////////////////////////////////////////////////////////////////////////
  // bit-time enable
  assign bit_tick = (div_reg == 8'(BIT_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 8'h00;
    end else if (bit_tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // remaining count, reload at the boundary after zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_time_left <= 14'h0000;
    end else if (bit_tick) begin
      if (bit_time_left == 14'h0000) begin
        bit_time_left <= frame_interval;
      end else begin
        bit_time_left <= bit_time_left - 14'h0001;
      end
    end
  end
endmodule

// [hdl/rh_port_power.sv]
// per-port power state under global and per-port commands
// assumes all command inputs are single-cycle pulses on clk_sys
`timescale 1ns/10ps
module rh_port_power #(
  parameter int NPORTS = 2
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              always_powered,
  input  wire logic              switching_mode,
  input  wire logic [15:0]       per_port_power_mask,
  input  wire logic              global_power_on_cmd,
  input  wire logic              global_power_off_cmd,
  input  wire logic [NPORTS-1:0] port_on_cmd,
  input  wire logic [NPORTS-1:0] port_off_cmd,
  input  wire logic              overcurrent,
  output logic      [NPORTS-1:0] port_power_on
);
  import rh_pkg::*;

  initial begin
    if (NPORTS < 1 || NPORTS > 15) $error("port count out of range");
  end

  genvar i;
  generate
    for (i = 0; i < NPORTS; i++) begin : g_port
      logic by_port;
      logic turn_on;
      logic turn_off;
      // mask bit i+1 belongs to port i+1; bit 0 is reserved
      assign by_port  = switching_mode && per_port_power_mask[i+1];
      assign turn_on  = by_port ? port_on_cmd[i] : global_power_on_cmd;
      assign turn_off = by_port ? port_off_cmd[i] : global_power_off_cmd;

      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          port_power_on[i] <= 1'b0;
        end else if (always_powered) begin
          port_power_on[i] <= 1'b1;
        end else if (overcurrent || turn_off) begin
          port_power_on[i] <= 1'b0;
        end else if (turn_on) begin
          port_power_on[i] <= 1'b1;
        end
      end
    end
  endgenerate
endmodule

// [hdl/rh_regs.sv]
// root hub descriptor, hub status and low-speed threshold registers
// assumes a simple same-clock register port; unmapped reads return zero
`timescale 1ns/10ps
`include "rh_map.svh"

module rh_regs #(
  parameter int NPORTS     = 2,
  parameter int BIT_CYCLES = `RH_BIT_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  input  wire logic [13:0]       frame_interval,
  input  wire logic              ls_request,
  output logic                   ls_start,
  output logic      [13:0]       bit_time_left,
  input  wire logic              overcurrent_pin,
  input  wire logic [NPORTS-1:0] port_on_cmd,
  input  wire logic [NPORTS-1:0] port_off_cmd,
  output logic      [NPORTS-1:0] port_power_on,
  input  wire logic [NPORTS-1:0] port_connect_change,
  input  wire logic              suspend_enter,
  input  wire logic              resume_done,
  output rh_pkg::rh_state_type   hub_state,
  output logic                   resume_detected,
  output logic      [NPORTS-1:0] nonremovable,
  output logic      [7:0]        power_good_wait
);
  import rh_pkg::*;

  initial begin
    if (NPORTS < 1 || NPORTS > 15) $error("port count must be 1 to 15");
  end

  logic [11:0]  lowspeed_threshold_reg;
  logic         no_overcurrent_protect_reg;
  logic         overcurrent_report_mode_reg;
  logic         always_powered_reg;
  logic         switching_mode_reg;
  logic [15:0]  per_port_power_mask_reg;
  logic [15:0]  nonremovable_mask_reg;
  logic         remote_wake_enable_reg;
  logic         global_overcurrent_reg;
  logic         overcurrent_change_reg;
  logic         global_on_reg;
  logic         global_off_reg;
  logic         oc_meta_reg;
  logic         oc_sync_reg;
  logic         oc_next;
  logic         wr_thr;
  logic         wr_desc_a;
  logic         wr_desc_b;
  logic         wr_status;
  logic         wake_event;
  logic [7:0]   port_count;
  logic [31:0]  rdata_next;
  rh_state_type state_next;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  assign wr_thr    = reg_wr && (reg_addr == `RH_OFS_LS_THRESHOLD);
  assign wr_desc_a = reg_wr && (reg_addr == `RH_OFS_DESCRIPTOR_A);
  assign wr_desc_b = reg_wr && (reg_addr == `RH_OFS_DESCRIPTOR_B);
  assign wr_status = reg_wr && (reg_addr == `RH_OFS_HUB_STATUS);
  assign port_count = 8'(NPORTS);

  ////////////////////////////////////////////////////////////////////////////
  // low-speed threshold
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lowspeed_threshold_reg <= `RH_LST_RESET;
    end else if (wr_thr) begin
      lowspeed_threshold_reg <= reg_wdata[11:0];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ls_start <= 1'b0;
    end else begin
      ls_start <= ls_request && (bit_time_left >= 14'(lowspeed_threshold_reg));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame bit-time counter
  rh_frame_timer #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_timer (
    .clk_sys        (clk_sys),
    .reset_n        (reset_n),
    .frame_interval (frame_interval),
    .bit_time_left  (bit_time_left)
  );

  ////////////////////////////////////////////////////////////////////////////
  // first descriptor
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      power_good_wait             <= `RH_PGW_RESET;
      no_overcurrent_protect_reg  <= `RH_NO_OVERCURRENT_PROTECT_RESET;
      overcurrent_report_mode_reg <= `RH_PSM_RESET;
      always_powered_reg          <= `RH_NPS_RESET;
      switching_mode_reg          <= `RH_PSM_RESET;
    end else if (wr_desc_a) begin
      power_good_wait             <= reg_wdata[`RH_A_PGW_HI:`RH_A_PGW_LO];
      no_overcurrent_protect_reg  <= reg_wdata[`RH_A_NO_OVERCURRENT_PROTECT];
      overcurrent_report_mode_reg <= reg_wdata[`RH_A_OVERCURRENT_REPORT_MODE];
      always_powered_reg          <= reg_wdata[`RH_A_NPS];
      switching_mode_reg          <= reg_wdata[`RH_A_PSM];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // second descriptor, bit 0 of each mask reserved
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      per_port_power_mask_reg <= 16'h0000;
      nonremovable_mask_reg   <= 16'h0000;
    end else if (wr_desc_b) begin
      per_port_power_mask_reg <= {reg_wdata[31:17], 1'b0};
      nonremovable_mask_reg   <= {reg_wdata[15:1], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nonremovable <= '0;
    end else begin
      nonremovable <= nonremovable_mask_reg[NPORTS:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hub status: remote wake enable, clear wins when both written
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      remote_wake_enable_reg <= 1'b0;
    end else if (wr_status && reg_wdata[`RH_S_CLR_WAKE]) begin
      remote_wake_enable_reg <= 1'b0;
    end else if (wr_status && reg_wdata[`RH_S_WAKE_EN]) begin
      remote_wake_enable_reg <= 1'b1;
    end
  end

  // global power command strobes, one cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      global_on_reg  <= 1'b0;
      global_off_reg <= 1'b0;
    end else begin
      global_on_reg  <= wr_status && reg_wdata[`RH_S_GLOBAL_ON];
      global_off_reg <= wr_status && reg_wdata[`RH_S_GLOBAL_OFF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overcurrent pin synchroniser and global indicator
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      oc_meta_reg <= 1'b0;
      oc_sync_reg <= 1'b0;
    end else begin
      oc_meta_reg <= overcurrent_pin;
      oc_sync_reg <= oc_meta_reg;
    end
  end

  // only collective reporting with protection present drives the bit
  assign oc_next = oc_sync_reg && !no_overcurrent_protect_reg
                   && !overcurrent_report_mode_reg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      global_overcurrent_reg <= 1'b0;
    end else begin
      global_overcurrent_reg <= oc_next;
    end
  end

  // change flag: hardware set beats software clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overcurrent_change_reg <= 1'b0;
    end else if (oc_next != global_overcurrent_reg) begin
      overcurrent_change_reg <= 1'b1;
    end else if (wr_status && reg_wdata[`RH_S_OC_CHANGE]) begin
      overcurrent_change_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // port power
  rh_port_power #(
    .NPORTS (NPORTS)
  ) u_power (
    .clk_sys              (clk_sys),
    .reset_n              (reset_n),
    .always_powered       (always_powered_reg),
    .switching_mode       (switching_mode_reg),
    .per_port_power_mask  (per_port_power_mask_reg),
    .global_power_on_cmd  (global_on_reg),
    .global_power_off_cmd (global_off_reg),
    .port_on_cmd          (port_on_cmd),
    .port_off_cmd         (port_off_cmd),
    .overcurrent          (global_overcurrent_reg),
    .port_power_on        (port_power_on)
  );

  ////////////////////////////////////////////////////////////////////////////
  // suspend and resume state
  assign wake_event = remote_wake_enable_reg && (|port_connect_change);

  always_comb begin
    state_next = hub_state;
    case (hub_state)
      RH_OPERATIONAL: begin
        if (suspend_enter) begin
          state_next = RH_SUSPEND;
        end
      end
      RH_SUSPEND: begin
        if (wake_event) begin
          state_next = RH_RESUME;
        end
      end
      RH_RESUME: begin
        if (resume_done) begin
          state_next = RH_OPERATIONAL;
        end
      end
      default: begin
        state_next = RH_OPERATIONAL;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hub_state <= RH_OPERATIONAL;
    end else begin
      hub_state <= state_next;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      resume_detected <= 1'b0;
    end else begin
      resume_detected <= (hub_state == RH_SUSPEND) && wake_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux, reserved and write-only bits read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
      `RH_OFS_LS_THRESHOLD: begin
        rdata_next[11:0] = lowspeed_threshold_reg;
      end
      `RH_OFS_DESCRIPTOR_A: begin
        rdata_next[`RH_A_PGW_HI:`RH_A_PGW_LO] = power_good_wait;
        rdata_next[`RH_A_NO_OVERCURRENT_PROTECT]     = no_overcurrent_protect_reg;
        rdata_next[`RH_A_OVERCURRENT_REPORT_MODE]     = overcurrent_report_mode_reg;
        rdata_next[`RH_A_COMPOUND] = 1'b0;
        rdata_next[`RH_A_NPS]      = always_powered_reg;
        rdata_next[`RH_A_PSM]      = switching_mode_reg;
        rdata_next[7:0]            = port_count;
      end
      `RH_OFS_DESCRIPTOR_B: begin
        rdata_next = {per_port_power_mask_reg, nonremovable_mask_reg};
      end
      `RH_OFS_HUB_STATUS: begin
        rdata_next[`RH_S_OC_CHANGE] = overcurrent_change_reg;
        rdata_next[`RH_S_WAKE_EN]   = remote_wake_enable_reg;
        rdata_next[`RH_S_GLOBAL_OC] = global_overcurrent_reg;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end
endmodule

// [tb/rh_regs_checker.sv]
// assertions on the root hub register block ports
// assumes binding into rh_regs; one clock, async active-low reset
`timescale 1ns/10ps
`include "rh_map.svh"
module rh_regs_checker #(
  parameter int NPORTS     = 2,
  parameter int BIT_CYCLES = 8
) (
  input wire logic                clk_sys,
  input wire logic                reset_n,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic [31:0]         reg_rdata,
  input wire logic [13:0]         frame_interval,
  input wire logic                ls_request,
  input wire logic                ls_start,
  input wire logic [13:0]         bit_time_left,
  input wire logic [NPORTS-1:0]   port_connect_change,
  input wire rh_pkg::rh_state_type hub_state,
  input wire logic                resume_detected,
  input wire logic [NPORTS-1:0]   port_power_on
);
  import rh_pkg::*;
  logic [11:0] thr_reg;
  logic        wake_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // shadows of threshold and wake enable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      thr_reg <= `RH_LST_RESET;
    end else if (reg_wr && reg_addr == `RH_OFS_LS_THRESHOLD) begin
      thr_reg <= reg_wdata[11:0];
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wake_reg <= 1'b0;
    end else if (reg_wr && reg_addr == `RH_OFS_HUB_STATUS) begin
      wake_reg <= reg_wdata[31] ? 1'b0 : (reg_wdata[15] | wake_reg);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_ls_start_go: assert property (ls_request && bit_time_left >= {2'b00, thr_reg} |=> ls_start)
    else $error("low-speed start missing");
  a_ls_start_no: assert property (!(ls_request && bit_time_left >= {2'b00, thr_reg})
    |=> !ls_start) else $error("low-speed start without room");
  a_left_step: assert property ($changed(bit_time_left) |->
    bit_time_left == $past(bit_time_left) - 14'h0001 ||
    ($past(bit_time_left) == 14'h0000 && bit_time_left == $past(frame_interval)))
    else $error("remaining count bad step");
  a_left_hold: assert property ($changed(bit_time_left) |=> $stable(bit_time_left))
    else $error("remaining count moved twice");
  a_wake_resume: assert property (hub_state == RH_SUSPEND && wake_reg && |port_connect_change
    |=> hub_state == RH_RESUME && resume_detected) else $error("no resume on wake");
  a_wake_off: assert property (hub_state == RH_SUSPEND && !wake_reg |=> !resume_detected)
    else $error("resume without wake enable");
  a_resume_once: assert property (resume_detected |=> !resume_detected)
    else $error("resume pulse too long");
  a_rd_unmapped: assert property (reg_rd && !(reg_addr inside {`RH_OFS_LS_THRESHOLD,
    `RH_OFS_DESCRIPTOR_A, `RH_OFS_DESCRIPTOR_B, `RH_OFS_HUB_STATUS})
    |=> reg_rdata == 32'h00000000) else $error("unmapped read not zero");
  a_rd_status: assert property (reg_rd && reg_addr == `RH_OFS_HUB_STATUS
    |=> (reg_rdata & 32'hFFFD7FFD) == 32'h00000000) else $error("status fixed bits set");
  a_rd_desc_a: assert property (reg_rd && reg_addr == `RH_OFS_DESCRIPTOR_A |=>
    reg_rdata[23:13] == 11'h000 && !reg_rdata[10] && reg_rdata[7:0] == 8'(NPORTS))
    else $error("descriptor fixed fields wrong");
  c_ls_start: cover property (ls_start);
  c_resume: cover property (resume_detected);
  c_power: cover property ($changed(port_power_on));
endmodule

bind rh_regs rh_regs_checker #(.NPORTS(NPORTS), .BIT_CYCLES(BIT_CYCLES)) u_checker (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .frame_interval(frame_interval), .ls_request(ls_request), .ls_start(ls_start),
  .bit_time_left(bit_time_left), .port_connect_change(port_connect_change),
  .hub_state(hub_state), .resume_detected(resume_detected), .port_power_on(port_power_on)
);

// [tb/rh_host_model.sv]
// host driver model: register writes and reads, power-good delay
// assumes the same-clock strobe port of rh_regs; drives on falling edges
`timescale 1ns/10ps
`include "rh_map.svh"
module rh_host_model #(
  parameter int MS_CYCLES = 4
) (
  input  wire logic        clk_sys,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = (a == `RH_OFS_HUB_STATUS) ? (d & 32'h80038003) : d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  // wait after power-on before touching a port
  task automatic power_good_delay(input logic [7:0] pgw);
    repeat (int'(pgw) * `RH_PGW_UNIT_MS * MS_CYCLES) @(negedge clk_sys);
  endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the root hub register block
// assumes rh_regs with two ports and a short bit-time divider
`timescale 1ns/10ps
`include "rh_map.svh"
module tb;
  import rh_pkg::*;
  logic         clk_sys, reset_n, reg_wr, reg_rd, ls_request, ls_start, overcurrent_pin;
  logic         suspend_enter, resume_done, resume_detected;
  logic [7:0]   reg_addr, power_good_wait;
  logic [31:0]  reg_wdata, reg_rdata;
  logic [13:0]  frame_interval, bit_time_left;
  logic [1:0]   port_on_cmd, port_off_cmd, port_power_on, port_connect_change, nonremovable;
  rh_state_type hub_state;
  int           err_count, checks_done, cycles;
  ////////////////////////////////////////////////////////////////////////////////
  rh_regs #(.NPORTS(2), .BIT_CYCLES(2)) u_dut (
    .clk_sys, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .frame_interval, .ls_request, .ls_start, .bit_time_left, .overcurrent_pin,
    .port_on_cmd, .port_off_cmd, .port_power_on, .port_connect_change, .suspend_enter,
    .resume_done, .hub_state, .resume_detected, .nonremovable, .power_good_wait
  );
  rh_host_model #(.MS_CYCLES(4)) u_host (
    .clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata
  );
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    u_host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic drive(input logic [1:0] on, input logic [1:0] off, input logic [1:0] cc,
                       input logic se, input logic rdn);
    @(negedge clk_sys);
    port_on_cmd = on;
    port_off_cmd = off;
    port_connect_change = cc;
    suspend_enter = se;
    resume_done = rdn;
    @(negedge clk_sys);
    port_on_cmd = 2'b00;
    port_off_cmd = 2'b00;
    port_connect_change = 2'b00;
    suspend_enter = 1'b0;
    resume_done = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdchk(`RH_OFS_LS_THRESHOLD, 32'h00000628);
    rdchk(`RH_OFS_DESCRIPTOR_A, 32'hFF000902);
    rdchk(`RH_OFS_DESCRIPTOR_B, 32'h00000000);
    rdchk(`RH_OFS_HUB_STATUS, 32'h00000000);
    rdchk(8'h54, 32'h00000000);
    chk({24'h0, power_good_wait}, 32'h000000FF);
  endtask
  task automatic t_desc();
    u_host.wr(`RH_OFS_DESCRIPTOR_A, 32'hFFFFFFFF);
    rdchk(`RH_OFS_DESCRIPTOR_A, 32'hFF001B02);
    u_host.wr(`RH_OFS_DESCRIPTOR_B, 32'hFFFFFFFF);
    rdchk(`RH_OFS_DESCRIPTOR_B, 32'hFFFEFFFE);
    chk({30'h0, nonremovable}, 32'h00000003);
    u_host.wr(`RH_OFS_DESCRIPTOR_B, 32'h00040002);
    chk({30'h0, nonremovable}, 32'h00000001);
    u_host.wr(`RH_OFS_DESCRIPTOR_A, 32'h03000100);
    chk({24'h0, power_good_wait}, 32'h00000003);
  endtask
  task automatic t_power();
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h00000001);
    drive(2'b00, 2'b10, 2'b00, 1'b0, 1'b0);
    chk({30'h0, port_power_on}, 32'h00000000);
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h00010000);
    chk({30'h0, port_power_on}, 32'h00000001);
    u_host.power_good_delay(power_good_wait);
    drive(2'b10, 2'b00, 2'b00, 1'b0, 1'b0);
    drive(2'b00, 2'b01, 2'b00, 1'b0, 1'b0);
    repeat (2) @(negedge clk_sys);
    chk({30'h0, port_power_on}, 32'h00000003);
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h00000001);
    chk({30'h0, port_power_on}, 32'h00000002);
    rdchk(`RH_OFS_HUB_STATUS, 32'h00000000);
    u_host.wr(`RH_OFS_DESCRIPTOR_A, 32'h03000000);
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h00010000);
    chk({30'h0, port_power_on}, 32'h00000003);
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h00000001);
    chk({30'h0, port_power_on}, 32'h00000000);
    u_host.wr(`RH_OFS_DESCRIPTOR_A, 32'h03000200);
    chk({30'h0, port_power_on}, 32'h00000003);
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h00000001);
    chk({30'h0, port_power_on}, 32'h00000003);
  endtask
  task automatic t_wake();
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h00008000);
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h00000000);
    rdchk(`RH_OFS_HUB_STATUS, 32'h00008000);
    drive(2'b00, 2'b00, 2'b00, 1'b1, 1'b0);
    chk({30'h0, hub_state}, {30'h0, RH_SUSPEND});
    drive(2'b00, 2'b00, 2'b10, 1'b0, 1'b0);
    chk({29'h0, resume_detected, hub_state}, {29'h0, 1'b1, RH_RESUME});
    @(negedge clk_sys);
    chk({31'h0, resume_detected}, 32'h00000000);
    drive(2'b00, 2'b00, 2'b00, 1'b0, 1'b1);
    chk({30'h0, hub_state}, {30'h0, RH_OPERATIONAL});
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h80000000);
    rdchk(`RH_OFS_HUB_STATUS, 32'h00000000);
    drive(2'b00, 2'b00, 2'b00, 1'b1, 1'b0);
    drive(2'b00, 2'b00, 2'b01, 1'b0, 1'b0);
    chk({29'h0, resume_detected, hub_state}, {29'h0, 1'b0, RH_SUSPEND});
  endtask
  task automatic t_overcurrent();
    u_host.wr(`RH_OFS_DESCRIPTOR_A, 32'h03000100);
    overcurrent_pin = 1'b1;
    repeat (5) @(negedge clk_sys);
    rdchk(`RH_OFS_HUB_STATUS, 32'h00020002);
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h00020000);
    rdchk(`RH_OFS_HUB_STATUS, 32'h00000002);
    overcurrent_pin = 1'b0;
    repeat (5) @(negedge clk_sys);
    rdchk(`RH_OFS_HUB_STATUS, 32'h00020000);
    u_host.wr(`RH_OFS_HUB_STATUS, 32'h00020000);
    u_host.wr(`RH_OFS_DESCRIPTOR_A, 32'h03000900);
    overcurrent_pin = 1'b1;
    repeat (5) @(negedge clk_sys);
    rdchk(`RH_OFS_HUB_STATUS, 32'h00000000);
    u_host.wr(`RH_OFS_DESCRIPTOR_A, 32'h03001100);
    rdchk(`RH_OFS_HUB_STATUS, 32'h00000000);
    overcurrent_pin = 1'b0;
  endtask
  task automatic t_lowspeed();
    logic [13:0] prev;
    logic        seen;
    seen = 1'b0;
    u_host.wr(`RH_OFS_LS_THRESHOLD, 32'hFFFFF6A0);
    rdchk(`RH_OFS_LS_THRESHOLD, 32'h000006A0);
    @(negedge clk_sys);
    ls_request = 1'b1;
    prev = bit_time_left;
    repeat (3700) begin
      @(negedge clk_sys);
      chk({31'h0, ls_start}, {31'h0, prev >= 14'h06A0});
      if (prev == 14'h0000 && bit_time_left === 14'h0700) seen = 1'b1;
      prev = bit_time_left;
    end
    ls_request = 1'b0;
    chk({31'h0, seen}, 32'h00000001);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    frame_interval = 14'h0700;
    ls_request = 1'b0;
    overcurrent_pin = 1'b0;
    port_on_cmd = 2'b00;
    port_off_cmd = 2'b00;
    port_connect_change = 2'b00;
    suspend_enter = 1'b0;
    resume_done = 1'b0;
    err_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (16) @(negedge clk_sys);
    chk({30'h0, port_power_on}, 32'h00000000);
    reset_n = 1'b1;
    t_reset();
    t_desc();
    t_power();
    t_wake();
    t_overcurrent();
    t_lowspeed();
    summarize();
  end
endmodule
